// ### core/cwg_top.sv
// AHB-Lite slave with three complementary waveform channels
module cwg_top
    import cwg_pkg::*;
(
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic      [31:0]             hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    input  wire logic [CWG_CHANNELS-1:0] pulse_in,
    input  wire logic [CWG_CHANNELS-1:0] shutdown_in,
    output logic      [CWG_CHANNELS-1:0] drive_output_a,
    output logic      [CWG_CHANNELS-1:0] drive_output_b,
    output logic      [CWG_CHANNELS-1:0] drive_output_c,
    output logic      [CWG_CHANNELS-1:0] drive_output_d
);
    // ============================================================
    // State
    typedef struct packed {
        cwg_cfg_type  [CWG_CHANNELS-1:0] cfg;
        cwg_chan_type [CWG_CHANNELS-1:0] ch;
        logic                            dp_wr;
        logic [1:0]                      dp_ch;
        logic [4:0]                      dp_ofs;
        logic [31:0]                     rdata;
    } cwg_state_type;

    cwg_state_type st_r;
    cwg_state_type st_nxt;

    logic       addr_ok;
    logic [1:0] addr_ch;
    logic [4:0] addr_ofs;
    logic       take;

    assign addr_ch   = haddr[CWG_CH_MSB:CWG_CH_LSB];
    assign addr_ofs  = haddr[CWG_CH_LSB-1:0];
    assign addr_ok   = (haddr[31:CWG_CH_MSB+1] == 25'h0000000) && (addr_ch < 2'h3);
    assign take      = hsel && hready && (htrans == CWG_HTRANS_NONSEQ);
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = st_r.rdata;

    // ============================================================
    // Next state
    always_comb begin
        logic                   edge_r;
        logic                   edge_f;
        logic                   a_mod;
        logic                   b_mod;
        logic                   sd_set;
        logic                   sd_clr;
        logic                   wsel;
        logic [3:0]             base;
        logic [3:0]             stv;
        cwg_cfg_type            c;
        edge_r = 1'b0;
        edge_f = 1'b0;
        a_mod  = 1'b0;
        b_mod  = 1'b0;
        sd_set = 1'b0;
        sd_clr = 1'b0;
        wsel   = 1'b0;
        base   = 4'h0;
        stv    = 4'h0;
        c      = '0;
        st_nxt = st_r;
        st_nxt.dp_wr = 1'b0;
        // Address phase
        if (take) begin
            st_nxt.dp_wr  = hwrite && addr_ok;
            st_nxt.dp_ch  = addr_ch;
            st_nxt.dp_ofs = addr_ofs;
            st_nxt.rdata  = 32'h00000000;
            if (!hwrite && addr_ok) begin
                c = st_r.cfg[addr_ch];
                case (addr_ofs)
                    CWG_OFS_CONTROL_0: st_nxt.rdata = {24'h000000, c.en, 4'h0, c.mode};
                    CWG_OFS_CONTROL_1: st_nxt.rdata = {26'h0000000, c.fall_en, c.rise_en,
                                                       c.pol};
                    CWG_OFS_RISE_DLY:  st_nxt.rdata = {26'h0000000, c.rise_dly};
                    CWG_OFS_FALL_DLY:  st_nxt.rdata = {26'h0000000, c.fall_dly};
                    CWG_OFS_SHUT_CTL:  st_nxt.rdata = {24'h000000, c.shut_lvl, 1'b0,
                                                       c.sw_shut, c.auto_restart, c.auto_en};
                    CWG_OFS_STEER:     st_nxt.rdata = {28'h0000000, c.steer};
                    CWG_OFS_STATUS:    st_nxt.rdata = {24'h000000, st_r.ch[addr_ch].out, 2'h0,
                                                       st_r.ch[addr_ch].in_d,
                                                       st_r.ch[addr_ch].shut};
                    default:           st_nxt.rdata = 32'h00000000;
                endcase
            end
        end
        for (int i = 0; i < CWG_CHANNELS; i++) begin
            // Data phase write
            wsel = st_r.dp_wr && (st_r.dp_ch == i[1:0]);
            if (wsel) begin
                case (st_r.dp_ofs)
                    CWG_OFS_CONTROL_0: begin
                        st_nxt.cfg[i].en   = hwdata[CWG_F_EN];
                        st_nxt.cfg[i].mode = hwdata[2:0];
                    end
                    CWG_OFS_CONTROL_1: begin
                        st_nxt.cfg[i].pol     = hwdata[3:0];
                        st_nxt.cfg[i].rise_en = hwdata[CWG_F_RISE_EN];
                        st_nxt.cfg[i].fall_en = hwdata[CWG_F_FALL_EN];
                    end
                    CWG_OFS_RISE_DLY: st_nxt.cfg[i].rise_dly = hwdata[CWG_DB_BITS-1:0];
                    CWG_OFS_FALL_DLY: st_nxt.cfg[i].fall_dly = hwdata[CWG_DB_BITS-1:0];
                    CWG_OFS_SHUT_CTL: begin
                        st_nxt.cfg[i].auto_en      = hwdata[CWG_F_AUTO_EN];
                        st_nxt.cfg[i].auto_restart = hwdata[CWG_F_RESTART];
                        st_nxt.cfg[i].sw_shut      = hwdata[CWG_F_SW_SHUT];
                        st_nxt.cfg[i].shut_lvl     = hwdata[CWG_F_LVL_LSB+3:CWG_F_LVL_LSB];
                    end
                    CWG_OFS_STEER: st_nxt.cfg[i].steer = hwdata[3:0];
                    default: ;
                endcase
            end
            c = st_r.cfg[i];
            // Synchronisers
            st_nxt.ch[i].in_s1 = pulse_in[i];
            st_nxt.ch[i].in_s2 = st_r.ch[i].in_s1;
            st_nxt.ch[i].in_d  = st_r.ch[i].in_s2;
            st_nxt.ch[i].sd_s1 = shutdown_in[i];
            st_nxt.ch[i].sd_s2 = st_r.ch[i].sd_s1;
            edge_r = st_r.ch[i].in_s2 && !st_r.ch[i].in_d;
            edge_f = !st_r.ch[i].in_s2 && st_r.ch[i].in_d;
            // Dead-band timers
            if (edge_r) begin
                st_nxt.ch[i].b_ok     = 1'b0;
                st_nxt.ch[i].fall_cnt = '0;
                if (c.rise_en && (c.rise_dly != 6'h00)) begin
                    st_nxt.ch[i].rise_cnt = c.rise_dly;
                    st_nxt.ch[i].a_ok     = 1'b0;
                end else begin
                    st_nxt.ch[i].a_ok = 1'b1;
                end
            end else if (st_r.ch[i].rise_cnt != 6'h00) begin
                st_nxt.ch[i].rise_cnt = st_r.ch[i].rise_cnt - 6'h01;
                st_nxt.ch[i].a_ok     = (st_r.ch[i].rise_cnt == 6'h01);
            end
            if (edge_f) begin
                st_nxt.ch[i].a_ok     = 1'b0;
                st_nxt.ch[i].rise_cnt = '0;
                if (c.fall_en && (c.fall_dly != 6'h00)) begin
                    st_nxt.ch[i].fall_cnt = c.fall_dly;
                    st_nxt.ch[i].b_ok     = 1'b0;
                end else begin
                    st_nxt.ch[i].b_ok = 1'b1;
                end
            end else if (st_r.ch[i].fall_cnt != 6'h00) begin
                st_nxt.ch[i].fall_cnt = st_r.ch[i].fall_cnt - 6'h01;
                st_nxt.ch[i].b_ok     = (st_r.ch[i].fall_cnt == 6'h01);
            end
            // Push-pull alternation and synchronous steering latch
            if (edge_r) begin
                st_nxt.ch[i].pp_sel     = !st_r.ch[i].pp_sel;
                st_nxt.ch[i].steer_sync = c.steer;
            end
            // Shutdown, set wins over clear
            sd_set = (c.auto_en && st_r.ch[i].sd_s2) || c.sw_shut;
            sd_clr = (c.auto_restart && !sd_set) ||
                     (wsel && (st_r.dp_ofs == CWG_OFS_STATUS) && hwdata[CWG_F_SHUT_STAT]);
            st_nxt.ch[i].shut = sd_set || (st_r.ch[i].shut && !sd_clr);
            // Waveforms
            a_mod = st_r.ch[i].in_d && st_r.ch[i].a_ok;
            b_mod = !st_r.ch[i].in_d && st_r.ch[i].b_ok;
            stv   = (c.mode == CWG_MODE_SSTEER) ? st_r.ch[i].steer_sync : c.steer;
            base  = 4'h0;
            if (c.en) begin
                case (c.mode)
                    CWG_MODE_HALF: base = {b_mod, a_mod, b_mod, a_mod};
                    CWG_MODE_PUSH: begin
                        base[0] = a_mod && st_r.ch[i].pp_sel;
                        base[1] = a_mod && !st_r.ch[i].pp_sel;
                        base[2] = base[0];
                        base[3] = base[1];
                    end
                    CWG_MODE_ASTEER: base = stv & {4{a_mod}};
                    CWG_MODE_SSTEER: base = stv & {4{a_mod}};
                    CWG_MODE_FWD:    base = {a_mod, 1'b0, 1'b0, 1'b1};
                    CWG_MODE_REV:    base = {1'b0, 1'b1, a_mod, 1'b0};
                    default:         base = 4'h0;
                endcase
            end
            if (st_r.ch[i].shut) begin
                st_nxt.ch[i].out = c.shut_lvl;
            end else begin
                st_nxt.ch[i].out = base ^ c.pol;
            end
        end
    end

    // ============================================================
    // Registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < CWG_CHANNELS; i++) begin
                st_r.cfg[i] <= '{en: 1'b0, mode: CWG_MODE_HALF, pol: CWG_RST_POL,
                                 rise_en: 1'b0, fall_en: 1'b0, rise_dly: CWG_RST_DLY,
                                 fall_dly: CWG_RST_DLY, auto_en: 1'b0, auto_restart: 1'b0,
                                 sw_shut: 1'b0, shut_lvl: CWG_RST_LVL,
                                 steer: CWG_RST_STEER};
                // Input idles low, so output B may drive
                st_r.ch[i]  <= '{b_ok: 1'b1, default: '0};
            end
            st_r.dp_wr  <= 1'b0;
            st_r.dp_ch  <= 2'h0;
            st_r.dp_ofs <= 5'h00;
            st_r.rdata  <= 32'h00000000;
        end else begin
            st_r <= st_nxt;
        end
    end

    for (genvar g = 0; g < CWG_CHANNELS; g++) begin : g_out
        assign drive_output_a[g] = st_r.ch[g].out[0];
        assign drive_output_b[g] = st_r.ch[g].out[1];
        assign drive_output_c[g] = st_r.ch[g].out[2];
        assign drive_output_d[g] = st_r.ch[g].out[3];

        // ========================================================
        // Checks
        logic hb_run;
        assign hb_run = st_r.cfg[g].en && (st_r.cfg[g].mode == CWG_MODE_HALF)
                        && !st_r.ch[g].shut && !st_nxt.ch[g].shut;

        chk_hb_overlap: assert property (
            @(posedge hclk) disable iff (!hresetn)
            (hb_run && $stable(st_r.cfg[g])) |=>
                !((st_r.ch[g].out[0] ^ $past(st_r.cfg[g].pol[0])) &&
                  (st_r.ch[g].out[1] ^ $past(st_r.cfg[g].pol[1]))))
            else $error("Half-bridge outputs overlap");

        chk_cd_mirror: assert property (
            @(posedge hclk) disable iff (!hresetn)
            (hb_run && $stable(st_r.cfg[g])) |=>
                ((st_r.ch[g].out[2] ^ $past(st_r.cfg[g].pol[2])) ==
                 (st_r.ch[g].out[0] ^ $past(st_r.cfg[g].pol[0]))) &&
                ((st_r.ch[g].out[3] ^ $past(st_r.cfg[g].pol[3])) ==
                 (st_r.ch[g].out[1] ^ $past(st_r.cfg[g].pol[1]))))
            else $error("Outputs C D do not mirror A B");

        chk_hb_follow: assert property (
            @(posedge hclk) disable iff (!hresetn)
            (hb_run && !st_r.cfg[g].rise_en && !st_r.cfg[g].fall_en && $stable(st_r.cfg[g])
             && st_r.ch[g].in_d == $past(st_r.ch[g].in_d)) |=>
                (st_r.ch[g].out[0] ^ $past(st_r.cfg[g].pol[0])) == $past(st_r.ch[g].in_d) &&
                (st_r.ch[g].out[1] ^ $past(st_r.cfg[g].pol[1])) == !$past(st_r.ch[g].in_d))
            else $error("Half-bridge outputs do not follow input");

        chk_rise_wait: assert property (
            @(posedge hclk) disable iff (!hresetn)
            (st_r.ch[g].in_s2 && !st_r.ch[g].in_d && st_r.cfg[g].rise_en &&
             st_r.cfg[g].rise_dly != 6'h00) |=>
                !st_r.ch[g].a_ok && st_r.ch[g].rise_cnt == $past(st_r.cfg[g].rise_dly))
            else $error("Rising dead band not started");

        chk_rise_skip: assert property (
            @(posedge hclk) disable iff (!hresetn)
            (st_r.ch[g].in_s2 && !st_r.ch[g].in_d && !st_r.cfg[g].rise_en) |=>
                st_r.ch[g].a_ok)
            else $error("Disabled rising dead band delays output");

        chk_fall_wait: assert property (
            @(posedge hclk) disable iff (!hresetn)
            (!st_r.ch[g].in_s2 && st_r.ch[g].in_d && st_r.cfg[g].fall_en &&
             st_r.cfg[g].fall_dly != 6'h00) |=>
                !st_r.ch[g].b_ok && st_r.ch[g].fall_cnt == $past(st_r.cfg[g].fall_dly))
            else $error("Falling dead band not started");

        chk_fall_done: assert property (
            @(posedge hclk) disable iff (!hresetn)
            $rose(st_r.ch[g].b_ok) |->
                ($past(st_r.ch[g].fall_cnt) == 6'h01) || $past(st_r.ch[g].in_d))
            else $error("Falling dead band ended off count");

        chk_db_counts: assert property (
            @(posedge hclk) disable iff (!hresetn)
            $rose(st_r.ch[g].a_ok) |->
                ($past(st_r.ch[g].rise_cnt) == 6'h01) || $past(st_r.ch[g].in_s2))
            else $error("Rising dead band ended off count");

        chk_shut_auto: assert property (
            @(posedge hclk) disable iff (!hresetn)
            (st_r.cfg[g].auto_en && st_r.ch[g].sd_s2) |=> st_r.ch[g].shut)
            else $error("Auto-shutdown not entered");

        chk_shut_levels: assert property (
            @(posedge hclk) disable iff (!hresetn)
            (st_r.ch[g].shut && $stable(st_r.cfg[g].shut_lvl)) |=>
                st_r.ch[g].out == $past(st_r.cfg[g].shut_lvl))
            else $error("Shutdown override levels not driven");

        chk_pin_to_off: assert property (
            @(posedge hclk) disable iff (!hresetn)
            ($rose(shutdown_in[g]) && st_r.cfg[g].auto_en) ##1 st_r.cfg[g].auto_en [*2]
                |=> ##1 st_r.ch[g].out == st_r.cfg[g].shut_lvl)
            else $error("Shutdown pin slow to override");

        chk_bad_mode: assert property (
            @(posedge hclk) disable iff (!hresetn)
            (st_r.cfg[g].mode > CWG_MODE_REV && !st_r.ch[g].shut && !st_nxt.ch[g].shut
             && $stable(st_r.cfg[g])) |=> st_r.ch[g].out == $past(st_r.cfg[g].pol))
            else $error("Unassigned mode drives outputs");

        chk_push_alt: assert property (
            @(posedge hclk) disable iff (!hresetn)
            (st_r.cfg[g].en && st_r.cfg[g].mode == CWG_MODE_PUSH && !st_r.ch[g].shut) |=>
                !((st_r.ch[g].out[0] ^ $past(st_r.cfg[g].pol[0])) &&
                  (st_r.ch[g].out[1] ^ $past(st_r.cfg[g].pol[1]))))
            else $error("Push-pull outputs both active");

        chk_shut_hold: assert property (
            @(posedge hclk) disable iff (!hresetn)
            (st_r.ch[g].shut && !st_r.cfg[g].auto_restart && !st_r.dp_wr) |=>
                st_r.ch[g].shut)
            else $error("Shutdown released without clear");

        chk_shut_soft: assert property (
            @(posedge hclk) disable iff (!hresetn)
            st_r.cfg[g].sw_shut |=> st_r.ch[g].shut)
            else $error("Software shutdown not entered");

        cov_hb_active: cover property (@(posedge hclk) disable iff (!hresetn)
            hb_run && st_r.ch[g].a_ok && st_r.ch[g].in_d);
        cov_shutdown: cover property (@(posedge hclk) disable iff (!hresetn)
            $rose(st_r.ch[g].shut));
        cov_push_pull: cover property (@(posedge hclk) disable iff (!hresetn)
            st_r.cfg[g].mode == CWG_MODE_PUSH && $changed(st_r.ch[g].pp_sel));
        cov_full_rev: cover property (@(posedge hclk) disable iff (!hresetn)
            st_r.cfg[g].en && st_r.cfg[g].mode == CWG_MODE_REV && st_r.ch[g].in_d);
        cov_dead_band: cover property (@(posedge hclk) disable iff (!hresetn)
            st_r.ch[g].rise_cnt == 6'h01);
    end
endmodule

// ### core/cwg_pkg.sv
// Constants, field layout and carrier types of the complementary waveform unit
// ============================================================
// How it works
// - Three independent generator channels exist
// - Two primary waveforms from selected pulse
// - Off-to-on edges delayed behind other's on-to-off
// - Faults end active drive promptly
// - Three-bit mode field selects six modes
// - One pulse input yields four outputs
// - Auto-shutdown acts in every mode
// - Half-bridge: A follows input, B inverse
// - Half-bridge inserts dead band, never overlapping
// - Steering ignored in half-bridge mode
// - C, D copy A, B with own polarity in half-bridge and push-pull modes
// - Two 6-bit dead-band timers count clocks
// - Rising and falling dead band enabled separately
// - Shutdown forces configured override levels
package cwg_pkg;
    // ============================================================
    // Structure
    localparam int          CWG_CHANNELS     = 3;
    localparam int          CWG_DB_BITS      = 6;
    // ============================================================
    // Register byte offsets within one channel
    localparam logic [4:0]  CWG_OFS_CONTROL_0 = 5'h00;
    localparam logic [4:0]  CWG_OFS_CONTROL_1 = 5'h04;
    localparam logic [4:0]  CWG_OFS_RISE_DLY  = 5'h08;
    localparam logic [4:0]  CWG_OFS_FALL_DLY  = 5'h0c;
    localparam logic [4:0]  CWG_OFS_SHUT_CTL  = 5'h10;
    localparam logic [4:0]  CWG_OFS_STEER     = 5'h14;
    localparam logic [4:0]  CWG_OFS_STATUS    = 5'h18;
    // Channel select field of the byte address
    localparam int          CWG_CH_LSB       = 5;
    localparam int          CWG_CH_MSB       = 6;
    // ============================================================
    // Field positions
    localparam int          CWG_F_EN         = 7;
    localparam int          CWG_F_RISE_EN    = 4;
    localparam int          CWG_F_FALL_EN    = 5;
    localparam int          CWG_F_AUTO_EN    = 0;
    localparam int          CWG_F_RESTART    = 1;
    localparam int          CWG_F_SW_SHUT    = 2;
    localparam int          CWG_F_LVL_LSB    = 4;
    localparam int          CWG_F_SHUT_STAT  = 0;
    localparam int          CWG_F_IN_STAT    = 1;
    // ============================================================
    // Mode encoding
    localparam logic [2:0]  CWG_MODE_HALF    = 3'h0;
    localparam logic [2:0]  CWG_MODE_PUSH    = 3'h1;
    localparam logic [2:0]  CWG_MODE_ASTEER  = 3'h2;
    localparam logic [2:0]  CWG_MODE_SSTEER  = 3'h3;
    localparam logic [2:0]  CWG_MODE_FWD     = 3'h4;
    localparam logic [2:0]  CWG_MODE_REV     = 3'h5;
    // ============================================================
    // Reset values and AHB transfer code
    localparam logic [3:0]  CWG_RST_POL      = 4'h0;
    localparam logic [3:0]  CWG_RST_LVL      = 4'h0;
    localparam logic [3:0]  CWG_RST_STEER    = 4'h0;
    localparam logic [5:0]  CWG_RST_DLY      = 6'h00;
    localparam logic [1:0]  CWG_HTRANS_NONSEQ = 2'h2;
    // ============================================================
    // Carriers
    typedef struct packed {
        logic                   en;
        logic [2:0]             mode;
        logic [3:0]             pol;
        logic                   rise_en;
        logic                   fall_en;
        logic [CWG_DB_BITS-1:0] rise_dly;
        logic [CWG_DB_BITS-1:0] fall_dly;
        logic                   auto_en;
        logic                   auto_restart;
        logic                   sw_shut;
        logic [3:0]             shut_lvl;
        logic [3:0]             steer;
    } cwg_cfg_type;

    typedef struct packed {
        logic                   in_s1;
        logic                   in_s2;
        logic                   in_d;
        logic                   sd_s1;
        logic                   sd_s2;
        logic [CWG_DB_BITS-1:0] rise_cnt;
        logic [CWG_DB_BITS-1:0] fall_cnt;
        logic                   a_ok;
        logic                   b_ok;
        logic                   pp_sel;
        logic                   shut;
        logic [3:0]             steer_sync;
        logic [3:0]             out;
    } cwg_chan_type;
endpackage

// ### verification/cwg_stage_model.sv
// Power stage model: shoot-through counter and fault feedback to the unit
module cwg_stage_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       arm,
    input  wire logic       fault_cmd,
    input  wire logic [2:0] gate_hi,
    input  wire logic [2:0] gate_lo,
    output logic      [2:0] fault_out,
    output int              overlaps
);
    timeunit 1ns;
    timeprecision 1ns;
    // ============================================================
    // Fault feedback and overlap watch
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_out <= 3'h0;
            overlaps  <= 0;
        end else begin
            fault_out <= {3{fault_cmd}};
            if (arm && (gate_hi & gate_lo) != 3'h0) begin
                overlaps <= overlaps + 1;
            end
        end
    end
endmodule

// ### verification/testbench.sv
// Self-checking bench of the complementary waveform unit
module testbench;
    import cwg_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, fault_cmd, arm;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans;
    logic [2:0]  hsize, pulse_in, shutdown_in, oa, ob, oc, od;
    int          mismatches, checks_done, cycles, overlaps, rdly, fdly, ta, tb;
    // Outputs per mode with input low, polarity 0x5
    localparam logic [3:0] LOW_EXP [8] = '{4'hf, 4'h5, 4'h5, 4'h5, 4'h4, 4'h1, 4'h5, 4'h5};

    cwg_top u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pulse_in(pulse_in), .shutdown_in(shutdown_in), .drive_output_a(oa),
        .drive_output_b(ob), .drive_output_c(oc), .drive_output_d(od));
    cwg_stage_model u_stage (.hclk(hclk), .hresetn(hresetn), .arm(arm),
        .fault_cmd(fault_cmd), .gate_hi(oa), .gate_lo(ob), .fault_out(shutdown_in),
        .overlaps(overlaps));

    always #5 hclk = ~hclk;
    // ============================================================
    // Helpers
    task automatic report_and_stop;
        if (mismatches == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            report_and_stop;
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            mismatches++;
        end
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= wr;
        htrans <= CWG_HTRANS_NONSEQ;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    function automatic logic [31:0] adr(input int ch, input logic [4:0] ofs);
        return 32'(ch * 32) + {27'h0, ofs};
    endfunction
    function automatic logic [3:0] outs(input int ch);
        return {od[ch], oc[ch], ob[ch], oa[ch]};
    endfunction
    // Half-bridge steady outputs: A follows, B inverts, C and D copy with polarity
    function automatic logic [3:0] model(input logic in, input logic [3:0] pol);
        return {~in, in, ~in, in} ^ pol;
    endfunction
    task automatic set_mode(input int ch, input logic [2:0] m);
        bus(1'b1, adr(ch, CWG_OFS_CONTROL_0), {29'h0, m});
        bus(1'b1, adr(ch, CWG_OFS_CONTROL_0), {24'h0, 5'h10, m});
        repeat (60) @(posedge hclk);
    endtask
    task automatic edge_run(input int ch, input logic lvl, input int exp_a, input int exp_b);
        int n;
        ta = -1;
        tb = -1;
        @(posedge hclk);
        pulse_in[ch] <= lvl;
        for (n = 1; n < 100; n++) begin
            @(posedge hclk);
            #1;
            if (ta < 0 && oa[ch] === lvl) ta = n;
            if (tb < 0 && ob[ch] === !lvl) tb = n;
        end
        check("output a edge delay", 32'(exp_a), 32'(ta));
        check("output b edge delay", 32'(exp_b), 32'(tb));
    endtask
    // ============================================================
    // Main sequence
    initial begin
        hclk = 0; hresetn = 0; hsel = 0; haddr = 0; hwrite = 0; htrans = 0;
        hsize = 3'h2; hwdata = 0; pulse_in = 0; fault_cmd = 0; arm = 0;
        mismatches = 0; checks_done = 0; cycles = 0;
        void'($urandom(69572));
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        for (int ch = 0; ch < 4; ch++) begin
            for (int o = 0; o < 8; o++) begin
                bus(1'b0, adr(ch, 5'(o * 4)), 32'h0);
                check("reset or unmapped read", 32'h0, rd);
            end
        end
        bus(1'b1, 32'h60, 32'hff);
        bus(1'b0, 32'h60, 32'h0);
        check("unmapped write ignored", 32'h0, rd);
        // ========================================================
        // Dead band per channel, random delays
        arm = 1'b1;
        for (int ch = 0; ch < 3; ch++) begin
            rdly = $urandom_range(1, 40);
            fdly = $urandom_range(1, 40);
            bus(1'b1, adr(ch, CWG_OFS_RISE_DLY), 32'(rdly));
            bus(1'b1, adr(ch, CWG_OFS_FALL_DLY), 32'(fdly));
            bus(1'b1, adr(ch, CWG_OFS_CONTROL_1), 32'h30);
            set_mode(ch, CWG_MODE_HALF);
            edge_run(ch, 1'b1, 4 + rdly, 4);
            edge_run(ch, 1'b0, 4, 4 + fdly);
            bus(1'b1, adr(ch, CWG_OFS_CONTROL_1), 32'h10);
            edge_run(ch, 1'b1, 4 + rdly, 4);
            edge_run(ch, 1'b0, 4, 4);
        end
        check("output overlap count", 32'h0, 32'(overlaps));
        // ========================================================
        // Polarity of C and D, steering ignored
        bus(1'b1, adr(1, CWG_OFS_STEER), 32'h0);
        bus(1'b1, adr(1, CWG_OFS_CONTROL_1), 32'h0c);
        repeat (6) @(posedge hclk);
        #1;
        check("half bridge low", {28'h0, model(1'b0, 4'hc)}, {28'h0, outs(1)});
        edge_run(1, 1'b1, 4, 4);
        check("half bridge high", {28'h0, model(1'b1, 4'hc)}, {28'h0, outs(1)});
        // ========================================================
        // Shutdown from the power stage
        bus(1'b1, adr(1, CWG_OFS_SHUT_CTL), 32'ha1);
        @(posedge hclk);
        fault_cmd <= 1'b1;
        repeat (6) @(posedge hclk);
        #1;
        check("pin shutdown levels", 32'ha, {28'h0, outs(1)});
        bus(1'b0, adr(1, CWG_OFS_STATUS), 32'h0);
        check("shutdown flag", 32'h1, {31'h0, rd[0]});
        @(posedge hclk);
        fault_cmd <= 1'b0;
        repeat (4) @(posedge hclk);
        bus(1'b1, adr(1, CWG_OFS_STATUS), 32'h1);
        repeat (6) @(posedge hclk);
        #1;
        check("after shutdown clear", {28'h0, model(1'b1, 4'hc)}, {28'h0, outs(1)});
        // ========================================================
        // Software shutdown in every mode, unassigned codes
        arm = 1'b0;
        bus(1'b1, adr(2, CWG_OFS_CONTROL_1), 32'h05);
        for (int m = 0; m < 8; m++) begin
            set_mode(2, 3'(m));
            bus(1'b0, adr(2, CWG_OFS_CONTROL_0), 32'h0);
            check("control 0 readback", 32'h80 | 32'(m), rd);
            bus(1'b1, adr(2, CWG_OFS_SHUT_CTL), 32'ha4);
            repeat (6) @(posedge hclk);
            #1;
            check("software shutdown levels", 32'ha, {28'h0, outs(2)});
            bus(1'b1, adr(2, CWG_OFS_SHUT_CTL), 32'h0);
            bus(1'b1, adr(2, CWG_OFS_STATUS), 32'h1);
            repeat (8) @(posedge hclk);
            #1;
            check("mode levels input low", {28'h0, LOW_EXP[m]}, {28'h0, outs(2)});
            bus(1'b1, adr(2, CWG_OFS_CONTROL_0), 32'(m));
        end
        report_and_stop;
    end
endmodule
